/* File: icis_pkg.sv */
// constants and types shared by the input change and interrupt status logic
package icis_pkg;
  // register data and address widths
  localparam int REG_W = 8;
  localparam int IDX_W = 6;
  localparam int NUM_PINS = 4;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  typedef logic [REG_W-1:0] icis_byte_t;
  typedef logic [IDX_W-1:0] icis_idx_t;
  // register indexes, byte address is four times the index
  localparam icis_idx_t IDX_INPUT_CHANGE = 6'h04;
  localparam icis_idx_t IDX_IRQ_STATUS = 6'h05;
  localparam icis_idx_t IDX_AUX_CONTROL = 6'h08;
  localparam icis_idx_t IDX_IRQ_MASK = 6'h09;
  localparam icis_idx_t IDX_COMMAND = 6'h0a;
  localparam icis_idx_t IDX_IRQ_PENDING = 6'h0b;
  // input change register fields
  localparam int CHG_LSB = 4;
  localparam int LVL_LSB = 0;
  // irq status bit positions
  localparam int ST_INPUT_CHG = 7;
  localparam int ST_BREAK_B = 6;
  localparam int ST_RX_B = 5;
  localparam int ST_TX_B = 4;
  localparam int ST_CTR_READY = 3;
  localparam int ST_BREAK_A = 2;
  localparam int ST_RX_A = 1;
  localparam int ST_TX_A = 0;
  // aux control fields
  localparam int AUX_EN_LSB = 0;
  localparam int AUX_CT_LSB = 4;
  localparam int AUX_CT_W = 3;
  localparam int AUX_BRG_BIT = 7;
  // command register bits, write one to act
  localparam int CMD_CLR_BREAK_A = 0;
  localparam int CMD_CLR_BREAK_B = 1;
  localparam int CMD_STOP_CTR = 2;
  // reset values
  localparam icis_byte_t RST_IRQ_STATUS = 8'h00;
  localparam icis_byte_t RST_IRQ_MASK = 8'h00;
  localparam icis_byte_t RST_AUX_CONTROL = 8'h00;
  localparam logic [NUM_PINS-1:0] RST_CHG = 4'h0;
endpackage

/* File: icis_reg_if.sv */
// register access strobes between the bus port and the core
`timescale 1ns/1ps
interface icis_reg_if;
  import icis_pkg::*;
  logic rd_setup;
  logic rd_take;
  logic wr_take;
  icis_idx_t idx;
  icis_byte_t wdata;
  icis_byte_t rdata;
  logic hit;
  logic wr_ok;
  modport port (output rd_setup, rd_take, wr_take, idx, wdata, input rdata, hit, wr_ok);
  modport core (input rd_setup, rd_take, wr_take, idx, wdata, output rdata, hit, wr_ok);
endinterface

/* File: icis_sync_detect.sv */
// per-pin two-stage synchroniser with change detection
`timescale 1ns/1ps
module icis_sync_detect #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins and results
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] pin_change
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      // first stage feeds only the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[g] <= 1'b0;
          pin_level[g] <= 1'b0;
          prev[g] <= 1'b0;
        end else begin
          meta[g] <= pin_raw[g];
          pin_level[g] <= meta[g];
          prev[g] <= pin_level[g];
        end
      end
      // one pulse per settled transition
      assign pin_change[g] = pin_level[g] ^ prev[g];
    end
  endgenerate
endmodule

/* File: icis_apb_port.sv */
// apb slave front end, zero wait states, registered read data
`timescale 1ns/1ps
module icis_apb_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [icis_pkg::APB_AW-1:0] paddr,
  input wire logic [icis_pkg::APB_DW-1:0] pwdata,
  output logic [icis_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  icis_reg_if.port regs
);
  import icis_pkg::*;
  logic err;
  logic setup;
  logic access;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  // strobes toward the core
  assign regs.idx = paddr[APB_AW-1:2];
  assign regs.wdata = pwdata[REG_W-1:0];
  assign regs.rd_setup = setup & ~pwrite;
  assign regs.rd_take = access & ~pwrite & ~err;
  assign regs.wr_take = access & pwrite & ~err;
  assign pready = 1'b1;
  assign pslverr = access & err;
  // read data and error decided in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      err <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : {{(APB_DW-REG_W){1'b0}}, regs.rdata};
      err <= ~regs.hit | (pwrite & ~regs.wr_ok) | (paddr[1:0] != 2'b00);
    end
  end
endmodule

/* File: icis_top.sv */
// input change detection and interrupt status gathering
//
// Overview of operation
// - a pin change sets its flag, bits 7..4, bit 7 is pin 3
// - reading the input change register clears the change flags that the read returned
// - that same read also clears status bit 7
// - bits 3..0 read the live pin levels, one means high
// - irq_out_n goes low when any status bit and its mask bit are one
// - a status bit with mask zero never affects irq_out_n
// - status reads return the unmasked state of every source
// - the status register is all zero after reset
// - status bit 7 sets on a pin change enabled in aux control bits 3..0
// - status bits 7..0 are input change, break B, rx B, tx B, ctr, break A, rx A, tx A
// - a disabled pin's change sets its flag but leaves status bit 7 alone
// - break change bits stay set until their reset command clears them
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module icis_top #(
  parameter int NUM_PINS = icis_pkg::NUM_PINS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [icis_pkg::APB_AW-1:0] paddr,
  input wire logic [icis_pkg::APB_DW-1:0] pwdata,
  output logic [icis_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // general purpose input pins
  input wire logic input_pin_0,
  input wire logic input_pin_1,
  input wire logic input_pin_2,
  input wire logic input_pin_3,
  // channel interrupt levels from the receivers and transmitters
  input wire logic rx_chan_a_irq,
  input wire logic tx_chan_a_irq,
  input wire logic rx_chan_b_irq,
  input wire logic tx_chan_b_irq,
  // one-cycle events from break detectors and counter
  input wire logic break_chg_a_evt,
  input wire logic break_chg_b_evt,
  input wire logic ctr_ready_evt,
  // counter stop request toward the counter
  output logic stop_ctr_cmd,
  // aux control fields used elsewhere
  output logic brg_set_sel,
  output logic [icis_pkg::AUX_CT_W-1:0] ctr_mode_sel,
  // interrupt output, active low
  output logic irq_out_n
);
  import icis_pkg::*;

  icis_reg_if regs ();

  // registers and state
  icis_byte_t irq_status_reg;
  icis_byte_t irq_mask_reg;
  icis_byte_t aux_control_reg;
  logic [NUM_PINS-1:0] chg_flag;
  logic [NUM_PINS-1:0] chg_snap;
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_change;
  logic [NUM_PINS-1:0] chg_en;
  logic [NUM_PINS-1:0] next_chg_flag;
  logic input_chg_set;
  logic next_input_chg;
  logic rd_change;
  logic wr_aux;
  logic wr_mask;
  logic wr_cmd;
  logic clr_break_a;
  logic clr_break_b;
  logic clr_ctr;
  logic next_break_a;
  logic next_break_b;
  logic next_ctr_ready;

  // bus front end
  icis_apb_port u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .regs(regs)
  );

  // pins gathered into a vector, pin 0 in the low bit
  assign pin_raw = {input_pin_3, input_pin_2, input_pin_1, input_pin_0};

  // synchroniser and change detector
  icis_sync_detect #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(pin_raw),
    .pin_level(pin_level),
    .pin_change(pin_change)
  );

  // access decode
  assign rd_change = regs.rd_take && (regs.idx == IDX_INPUT_CHANGE);
  assign wr_aux = regs.wr_take && (regs.idx == IDX_AUX_CONTROL);
  assign wr_mask = regs.wr_take && (regs.idx == IDX_IRQ_MASK);
  assign wr_cmd = regs.wr_take && (regs.idx == IDX_COMMAND);

  // command bits, acted on only in the write cycle
  assign clr_break_a = wr_cmd & regs.wdata[CMD_CLR_BREAK_A];
  assign clr_break_b = wr_cmd & regs.wdata[CMD_CLR_BREAK_B];
  assign clr_ctr = wr_cmd & regs.wdata[CMD_STOP_CTR];
  assign stop_ctr_cmd = clr_ctr;

  // aux control outputs
  assign chg_en = aux_control_reg[AUX_EN_LSB +: NUM_PINS];
  assign brg_set_sel = aux_control_reg[AUX_BRG_BIT];
  assign ctr_mode_sel = aux_control_reg[AUX_CT_LSB +: AUX_CT_W];

  // decode of mapped addresses
  always_comb begin
    regs.hit = 1'b0;
    regs.wr_ok = 1'b0;
    unique case (regs.idx)
      IDX_INPUT_CHANGE, IDX_IRQ_STATUS, IDX_IRQ_PENDING: begin
        regs.hit = 1'b1;
      end
      IDX_AUX_CONTROL, IDX_IRQ_MASK, IDX_COMMAND: begin
        regs.hit = 1'b1;
        regs.wr_ok = 1'b1;
      end
      default: begin
        regs.hit = 1'b0;
      end
    endcase
  end

  // read data mux, sampled in the setup cycle
  always_comb begin
    regs.rdata = 8'h00;
    unique case (regs.idx)
      IDX_INPUT_CHANGE: begin
        regs.rdata[CHG_LSB +: NUM_PINS] = chg_flag;
        regs.rdata[LVL_LSB +: NUM_PINS] = pin_level;
      end
      IDX_IRQ_STATUS: begin
        regs.rdata = irq_status_reg;
      end
      IDX_IRQ_PENDING: begin
        regs.rdata = irq_status_reg & irq_mask_reg;
      end
      IDX_AUX_CONTROL: begin
        regs.rdata = aux_control_reg;
      end
      IDX_IRQ_MASK: begin
        regs.rdata = irq_mask_reg;
      end
      default: begin
        regs.rdata = 8'h00;
      end
    endcase
  end

  // snapshot of flags shown to the reader, so later sets survive the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_snap <= RST_CHG;
    end else if (regs.rd_setup) begin
      chg_snap <= (regs.idx == IDX_INPUT_CHANGE) ? chg_flag : RST_CHG;
    end
  end

  // change flags: set on a settled edge, set wins over the read clear
  always_comb begin
    next_chg_flag = chg_flag;
    if (rd_change) begin
      next_chg_flag = chg_flag & ~chg_snap;
    end
    next_chg_flag = next_chg_flag | pin_change;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_flag <= RST_CHG;
    end else begin
      chg_flag <= next_chg_flag;
    end
  end

  // summary bit raised only through enabled pins
  assign input_chg_set = |(pin_change & chg_en);

  always_comb begin
    next_input_chg = irq_status_reg[ST_INPUT_CHG];
    if (rd_change) begin
      next_input_chg = 1'b0;
    end
    if (input_chg_set) begin
      next_input_chg = 1'b1;
    end
  end

  // break and counter bits: event sets, command clears, set wins
  always_comb begin
    next_break_a = (irq_status_reg[ST_BREAK_A] & ~clr_break_a) | break_chg_a_evt;
    next_break_b = (irq_status_reg[ST_BREAK_B] & ~clr_break_b) | break_chg_b_evt;
    next_ctr_ready = (irq_status_reg[ST_CTR_READY] & ~clr_ctr) | ctr_ready_evt;
  end

  // status register, one bit per source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= RST_IRQ_STATUS;
    end else begin
      irq_status_reg[ST_INPUT_CHG] <= next_input_chg;
      irq_status_reg[ST_BREAK_B] <= next_break_b;
      irq_status_reg[ST_RX_B] <= rx_chan_b_irq;
      irq_status_reg[ST_TX_B] <= tx_chan_b_irq;
      irq_status_reg[ST_CTR_READY] <= next_ctr_ready;
      irq_status_reg[ST_BREAK_A] <= next_break_a;
      irq_status_reg[ST_RX_A] <= rx_chan_a_irq;
      irq_status_reg[ST_TX_A] <= tx_chan_a_irq;
    end
  end

  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask_reg <= regs.wdata;
    end
  end

  // aux control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_control_reg <= RST_AUX_CONTROL;
    end else if (wr_aux) begin
      aux_control_reg <= regs.wdata;
    end
  end

  // interrupt output, masked bits have no effect
  assign irq_out_n = ~|(irq_status_reg & irq_mask_reg);

endmodule

/* File: icis_top_asserts.sv */
// port-level assertions for the input change and status block
`timescale 1ns/1ps
module icis_top_asserts (
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [icis_pkg::APB_AW-1:0] paddr,
  input wire logic [icis_pkg::APB_DW-1:0] pwdata,
  input wire logic [icis_pkg::APB_DW-1:0] prdata,
  input wire logic pslverr,
  // pins, one source and the interrupt
  input wire logic input_pin_0,
  input wire logic input_pin_1,
  input wire logic input_pin_2,
  input wire logic input_pin_3,
  input wire logic rx_chan_a_irq,
  input wire logic irq_out_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] pins;
  logic [7:0] mask_q;
  logic acc;
  // pin vector and access phase
  assign pins = {input_pin_3, input_pin_2, input_pin_1, input_pin_0};
  assign acc = psel && penable;
  // shadow of the mask, written at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 8'h00;
    end else if (acc && pwrite && paddr == 8'h24) begin
      mask_q <= pwdata[7:0];
    end
  end
  sequence rd_setup10;
    psel && !penable && !pwrite && paddr == 8'h10;
  endsequence
  a_reset_quiet: assert property ($rose(presetn) |-> irq_out_n && prdata == 32'h0)
    else $error("outputs not idle after reset");
  a_level_read: assert property ($stable(pins)[*3] ##0 rd_setup10 |=> prdata[3:0] == $past(pins))
    else $error("level bits differ from pins");
  a_flags_cleared: assert property ($stable(pins)[*4] ##0 (acc && !pwrite && paddr == 8'h10) ##2 rd_setup10
    |=> prdata[7:4] == 4'h0) else $error("flags survive a read");
  a_flag_sets: assert property ($changed(input_pin_0) ##1 ($stable(pins) && !acc)[*4] ##0 rd_setup10
    |=> prdata[4]) else $error("pin 0 flag not set");
  a_mask_blocks: assert property (mask_q == 8'h00 |-> irq_out_n)
    else $error("irq with empty mask");
  a_mask_passes: assert property (rx_chan_a_irq && mask_q[1] && !(acc && pwrite) |=> !irq_out_n)
    else $error("unmasked source gives no irq");
  a_status_ro: assert property (acc && pwrite && paddr == 8'h14 |-> pslverr)
    else $error("status write not refused");
  a_clear_summary: assert property ($stable(pins)[*4] ##0 (acc && !pwrite && paddr == 8'h10 && mask_q == 8'h80)
    |=> irq_out_n) else $error("summary bit not cleared");
  // main scenarios reached
  c_read_chg: cover property (rd_setup10);
  c_irq: cover property (!irq_out_n);
  c_refused: cover property (acc && pslverr);
endmodule
bind icis_top icis_top_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pslverr, .input_pin_0, .input_pin_1, .input_pin_2, .input_pin_3, .rx_chan_a_irq, .irq_out_n);

/* File: icis_host_model.sv */
// apb master standing in for the host processor
`timescale 1ns/1ps
module icis_host_model (
  // clock
  input wire logic pclk,
  // apb
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // one transfer, held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule

/* File: icis_top_bench.sv */
// self-checking bench for the input change and status block
`timescale 1ns/1ps
module icis_top_bench;
  import icis_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_ctr_cmd, brg_set_sel, irq_out_n, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pin;
  logic [3:0] lvl;
  logic [2:0] evt;
  logic [AUX_CT_W-1:0] ctr_mode_sel;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_stop = 0;
  icis_top i_icis_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .input_pin_0(pin[0]), .input_pin_1(pin[1]), .input_pin_2(pin[2]), .input_pin_3(pin[3]),
    .rx_chan_a_irq(lvl[0]), .tx_chan_a_irq(lvl[1]), .rx_chan_b_irq(lvl[2]), .tx_chan_b_irq(lvl[3]),
    .break_chg_a_evt(evt[0]), .break_chg_b_evt(evt[1]), .ctr_ready_evt(evt[2]),
    .stop_ctr_cmd, .brg_set_sel, .ctr_mode_sel, .irq_out_n);
  icis_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // 20 mhz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // counts stop counter pulses seen at the access edge
  always @(posedge pclk) begin
    if (stop_ctr_cmd === 1'b1) begin
      n_stop <= n_stop + 1;
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic test_done;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // register access helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, rd, err);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, {24'h0, exp});
  endtask
  // new pin levels, then time for sync and detect
  task automatic set_pins(input logic [3:0] v);
    @(posedge pclk);
    pin <= v;
    repeat (3) @(posedge pclk);
  endtask
  // main sequence
  initial begin
    {presetn, pin, lvl, evt} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(irq_out_n, 1'b1);
    rdc(8'h14, 8'h00);
    set_pins(4'ha);
    rdc(8'h10, 8'haa);
    rdc(8'h10, 8'h0a);
    rdc(8'h14, 8'h00);
    wr(8'h20, 8'hd1);
    rdc(8'h20, 8'hd1);
    chk({brg_set_sel, ctr_mode_sel}, 4'hd);
    wr(8'h24, 8'h80);
    set_pins(4'h2);
    #1 chk(irq_out_n, 1'b1);
    set_pins(4'h3);
    #1 chk(irq_out_n, 1'b0);
    rdc(8'h10, 8'h93);
    #1 chk(irq_out_n, 1'b1);
    rdc(8'h14, 8'h00);
    wr(8'h24, 8'h00);
    @(posedge pclk);
    lvl <= 4'hf;
    @(posedge pclk);
    evt <= 3'b111;
    @(posedge pclk);
    evt <= 3'b000;
    rdc(8'h14, 8'h7f);
    chk(irq_out_n, 1'b1);
    for (int i = 0; i < 7; i++) begin
      wr(8'h24, 8'h01 << i);
      #1 chk(irq_out_n, 1'b0);
    end
    rdc(8'h2c, 8'h40);
    rdc(8'h14, 8'h7f);
    wr(8'h28, 8'h01);
    rdc(8'h14, 8'h7b);
    wr(8'h28, 8'h02);
    rdc(8'h14, 8'h3b);
    host.xfer(1'b1, 8'h14, 32'hff, rd, err);
    chk(err, 1'b1);
    rdc(8'h14, 8'h3b);
    lvl <= 4'h0;
    wr(8'h28, 8'h04);
    rdc(8'h14, 8'h00);
    // sticky bits set again, then a reset in mid-run must clear them
    @(posedge pclk);
    evt <= 3'b111;
    @(posedge pclk);
    evt <= 3'b000;
    rdc(8'h14, 8'h4c);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h14, 8'h00);
    chk({brg_set_sel, ctr_mode_sel}, 4'h0);
    host.xfer(1'b0, 8'h3c, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    chk(n_stop, 32'd1);
    test_done;
  end
  // hang guard
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
endmodule
